// ==== rtl/async_mem_map.svh ====
// timing counts and reset values of the asynchronous memory sequencer
// assumes one system clock for the whole block
`ifndef ASYNC_MEM_MAP_SVH
`define ASYNC_MEM_MAP_SVH

// extended wait: clock periods per external wait cycle
`define ASM_WAIT_CHUNK_CYC 16
// wait_input deassert to strobe rise, clock periods
`define ASM_WAIT_RELEASE_CYC 4
// reset value of the memory data and address outputs
`define ASM_DATA_RST 16'h0000
`define ASM_ADDR_RST 21'h000000
`define ASM_BANK_RST 2'h0

`endif

// ==== rtl/async_mem_pkg.sv ====
// types of the asynchronous memory sequencer
// assumes the constants of async_mem_map.svh
package async_mem_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_EXTEND = 3'b011,
    ST_RELEASE = 3'b100,
    ST_HOLD = 3'b101,
    ST_TURN = 3'b110
  } seq_state_type;

endpackage

// ==== rtl/phase_timer.sv ====
// loadable down counter that marks the last cycle of a phase
// assumes a synchronous active high reset
`timescale 1ns/10ps
`default_nettype none

module phase_timer #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // load: a length of zero counts as one cycle
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_length,
  // last cycle of the loaded length
  output logic o_last
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  wire logic len_zero = (i_length == '0);

  generate
    if (WIDTH < 2) begin : g_bad_width
      $error("phase_timer width below 2");
    end
  endgenerate

  assign count_d = i_load ? (len_zero ? '0 : i_length - WIDTH'(1)) :
                   (count_q == '0) ? '0 : count_q - WIDTH'(1);
  assign o_last = (count_q == '0);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule // phase_timer

`default_nettype wire

// ==== rtl/async_memory_strobe_sequencer.sv ====
// strobe sequencer for asynchronous sram and nor memory
// assumes memory pins synchronous to i_clk and a stable config during each access
`timescale 1ns/10ps
`default_nettype none
`include "async_mem_map.svh"

// Behaviour
// - without extended wait a read takes read setup plus strobe plus hold cycles
// - with extended wait a read grows sixteen cycles per external wait cycle
// - chip select spans setup and hold, or follows the read strobe in strobe mode
// - read address and bank are valid from setup through hold
// - read strobe low for strobe cycles plus sixteen per wait cycle
// - read strobe rises four cycles after wait_input drops
// - without extended wait a write takes write setup plus strobe plus hold cycles
// - with extended wait a write grows sixteen cycles per external wait cycle
// - chip select spans write setup and hold, or follows the write strobe
// - write address and bank are valid from setup through hold
// - write strobe low for strobe cycles plus sixteen per wait cycle
// - write strobe rises four cycles after wait_input drops
// - write data is driven from write setup through write hold
// - wait cycles are counted and end in a timeout at the programmed limit
// - setup, strobe, hold, turnaround and timeout counts come from configuration inputs latched per access; wait chunk and release are fixed
module async_memory_strobe_sequencer #(
  parameter int SETUP_W = 4,
  parameter int STROBE_W = 6,
  parameter int HOLD_W = 3,
  parameter int TURN_W = 2,
  parameter int WAIT_W = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // access request
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic [1:0] i_req_space,
  input wire logic [1:0] i_req_bank,
  input wire logic [20:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  // access answer
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_rdata,
  output logic o_rsp_timeout,
  // configuration
  input wire logic [SETUP_W-1:0] i_read_setup_cycles,
  input wire logic [STROBE_W-1:0] i_read_strobe_cycles,
  input wire logic [HOLD_W-1:0] i_read_hold_cycles,
  input wire logic [SETUP_W-1:0] i_write_setup_cycles,
  input wire logic [STROBE_W-1:0] i_write_strobe_cycles,
  input wire logic [HOLD_W-1:0] i_write_hold_cycles,
  input wire logic [TURN_W-1:0] i_bus_turnaround_cycles,
  input wire logic i_extended_wait_enable,
  input wire logic i_select_strobe_mode,
  input wire logic [WAIT_W-1:0] i_wait_timeout_limit,
  // status
  output logic o_busy,
  output logic [WAIT_W-1:0] o_external_wait_count,
  // memory pins
  output logic [3:0] o_chip_select_n,
  output logic o_output_enable_n,
  output logic o_write_strobe_n,
  output logic [1:0] o_bank_addr,
  output logic [20:0] o_ext_addr,
  output logic [15:0] o_ext_data_out,
  output logic o_ext_data_oe,
  input wire logic [15:0] i_ext_data_in,
  input wire logic i_wait_input
);

  localparam int PHASE_W = STROBE_W;

  generate
    if (SETUP_W > PHASE_W || HOLD_W > PHASE_W || TURN_W > PHASE_W || PHASE_W < 3) begin : g_bad_cfg
      $error("phase widths must not exceed the strobe width");
    end
  endgenerate

  // ****************************************
  // access state
  // ****************************************
  async_mem_pkg::seq_state_type state_q;
  async_mem_pkg::seq_state_type state_d;
  logic wr_q;
  logic ew_q;
  logic ss_q;
  logic [1:0] space_q;
  logic [SETUP_W-1:0] setup_q;
  logic [STROBE_W-1:0] strobe_q;
  logic [HOLD_W-1:0] hold_q;
  logic [TURN_W-1:0] turn_q;
  logic [WAIT_W-1:0] limit_q;
  logic [WAIT_W-1:0] ewc_q;
  logic timeout_q;
  logic ext_used_q;
  logic phase_last;
  logic chunk_last;

  wire logic accept = (state_q == async_mem_pkg::ST_IDLE) && i_req_valid;
  wire logic in_setup = (state_q == async_mem_pkg::ST_SETUP);
  wire logic in_strobe = (state_q == async_mem_pkg::ST_STROBE);
  wire logic in_extend = (state_q == async_mem_pkg::ST_EXTEND);
  wire logic in_release = (state_q == async_mem_pkg::ST_RELEASE);
  wire logic in_hold = (state_q == async_mem_pkg::ST_HOLD);
  wire logic in_turn = (state_q == async_mem_pkg::ST_TURN);
  wire logic wait_hit = ew_q && i_wait_input;
  wire logic wait_limit = chunk_last && ((ewc_q + WAIT_W'(1)) >= limit_q);
  wire logic hold_end = in_hold && phase_last;
  wire logic to_hold = (state_d == async_mem_pkg::ST_HOLD) && !in_hold;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      async_mem_pkg::ST_IDLE: if (i_req_valid) state_d = async_mem_pkg::ST_SETUP;
      async_mem_pkg::ST_SETUP: if (phase_last) state_d = async_mem_pkg::ST_STROBE;
      async_mem_pkg::ST_STROBE: begin
        if (phase_last) state_d = wait_hit ? async_mem_pkg::ST_EXTEND : async_mem_pkg::ST_HOLD;
      end
      async_mem_pkg::ST_EXTEND: begin
        if (!i_wait_input) state_d = async_mem_pkg::ST_RELEASE;
        else if (wait_limit) state_d = async_mem_pkg::ST_HOLD;
      end
      async_mem_pkg::ST_RELEASE: if (phase_last) state_d = async_mem_pkg::ST_HOLD;
      async_mem_pkg::ST_HOLD: begin
        if (phase_last) state_d = (turn_q != '0) ? async_mem_pkg::ST_TURN : async_mem_pkg::ST_IDLE;
      end
      async_mem_pkg::ST_TURN: if (phase_last) state_d = async_mem_pkg::ST_IDLE;
      default: state_d = async_mem_pkg::ST_IDLE;
    endcase
  end

  // ****************************************
  // phase and wait timers
  // ****************************************
  logic [PHASE_W-1:0] phase_len;
  wire logic phase_load = (state_d != state_q);
  wire logic chunk_load = (in_strobe && state_d == async_mem_pkg::ST_EXTEND) || (in_extend && chunk_last);
  wire logic [SETUP_W-1:0] setup_sel = accept ? (i_req_write ? i_write_setup_cycles : i_read_setup_cycles) : setup_q;

  // phase lengths from latched settings, release from the fixed count, setup from the inputs at acceptance
  always_comb begin
    phase_len = '0;
    unique case (state_d)
      async_mem_pkg::ST_SETUP: phase_len = PHASE_W'(setup_sel);
      async_mem_pkg::ST_STROBE: phase_len = PHASE_W'(strobe_q);
      async_mem_pkg::ST_RELEASE: phase_len = PHASE_W'(`ASM_WAIT_RELEASE_CYC - 1);
      async_mem_pkg::ST_HOLD: phase_len = PHASE_W'(hold_q);
      async_mem_pkg::ST_TURN: phase_len = PHASE_W'(turn_q);
      default: phase_len = '0;
    endcase
  end

  phase_timer #(.WIDTH(PHASE_W)) u_phase_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(phase_load),
    .i_length(phase_len),
    .o_last(phase_last)
  );

  phase_timer #(.WIDTH(5)) u_chunk_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(chunk_load),
    .i_length(5'(`ASM_WAIT_CHUNK_CYC)),
    .o_last(chunk_last)
  );

  // ****************************************
  // latched access and settings
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= async_mem_pkg::ST_IDLE;
      wr_q <= 1'b0;
      ew_q <= 1'b0;
      ss_q <= 1'b0;
      space_q <= 2'h0;
      setup_q <= '0;
      strobe_q <= '0;
      hold_q <= '0;
      turn_q <= '0;
      limit_q <= '0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        wr_q <= i_req_write;
        ew_q <= i_extended_wait_enable;
        ss_q <= i_select_strobe_mode;
        space_q <= i_req_space;
        setup_q <= i_req_write ? i_write_setup_cycles : i_read_setup_cycles;
        strobe_q <= i_req_write ? i_write_strobe_cycles : i_read_strobe_cycles;
        hold_q <= i_req_write ? i_write_hold_cycles : i_read_hold_cycles;
        turn_q <= i_bus_turnaround_cycles;
        limit_q <= i_wait_timeout_limit;
      end
    end
  end

  // wait counting and timeout
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ewc_q <= '0;
      timeout_q <= 1'b0;
      ext_used_q <= 1'b0;
    end else if (accept) begin
      ewc_q <= '0;
      timeout_q <= 1'b0;
      ext_used_q <= 1'b0;
    end else begin
      if (chunk_load && in_strobe) ext_used_q <= 1'b1;
      if (in_extend && chunk_last && ewc_q != '1) ewc_q <= ewc_q + WAIT_W'(1);
      if (in_extend && i_wait_input && wait_limit) timeout_q <= 1'b1;
    end
  end

  // ****************************************
  // memory pins
  // ****************************************
  wire logic d_strobe = (state_d == async_mem_pkg::ST_STROBE) || (state_d == async_mem_pkg::ST_EXTEND) ||
                        (state_d == async_mem_pkg::ST_RELEASE);
  wire logic d_frame = d_strobe || (state_d == async_mem_pkg::ST_SETUP) || (state_d == async_mem_pkg::ST_HOLD);
  wire logic d_write = accept ? i_req_write : wr_q;
  wire logic [1:0] d_space = accept ? i_req_space : space_q;
  wire logic d_ss = accept ? i_select_strobe_mode : ss_q;
  wire logic cs_on = d_ss ? d_strobe : d_frame;
  wire logic [3:0] cs_dec = 4'h1 << d_space;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_chip_select_n <= 4'hF;
      o_output_enable_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_ext_data_oe <= 1'b0;
    end else begin
      o_chip_select_n <= cs_on ? ~cs_dec : 4'hF;
      o_output_enable_n <= !(d_strobe && !d_write);
      o_write_strobe_n <= !(d_strobe && d_write);
      o_ext_data_oe <= d_frame && d_write;
    end
  end

  // address and data held from acceptance to the next one
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ext_addr <= `ASM_ADDR_RST;
      o_bank_addr <= `ASM_BANK_RST;
      o_ext_data_out <= `ASM_DATA_RST;
    end else if (accept) begin
      o_ext_addr <= i_req_addr;
      o_bank_addr <= i_req_bank;
      o_ext_data_out <= i_req_wdata;
    end
  end

  // ****************************************
  // answer
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= `ASM_DATA_RST;
      o_rsp_timeout <= 1'b0;
    end else begin
      o_rsp_valid <= hold_end;
      if (hold_end) o_rsp_timeout <= timeout_q;
      if (to_hold && !wr_q) o_rsp_rdata <= i_ext_data_in;
    end
  end

  assign o_req_ready = (state_q == async_mem_pkg::ST_IDLE);
  assign o_busy = !o_req_ready;
  assign o_external_wait_count = ewc_q;

  // ****************************************
  // checks
  // ****************************************
  logic [7:0] acc_cnt_q;
  logic [STROBE_W:0] low_cnt_q;
  wire logic [7:0] eff_total = 8'(setup_q == '0 ? 1 : setup_q) + 8'(strobe_q == '0 ? 1 : strobe_q) +
                               8'(hold_q == '0 ? 1 : hold_q);
  wire logic [STROBE_W:0] eff_strobe = (STROBE_W+1)'(strobe_q == '0 ? 1 : strobe_q);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || accept) begin
      acc_cnt_q <= '0;
      low_cnt_q <= '0;
    end else begin
      if (!in_turn && !o_req_ready) acc_cnt_q <= acc_cnt_q + 8'(1);
      low_cnt_q <= (o_output_enable_n && o_write_strobe_n) ? '0 : low_cnt_q + (STROBE_W+1)'(1);
    end
  end

  a_read_cycle_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (hold_end && !wr_q && !ext_used_q) |-> (acc_cnt_q + 8'(1) == eff_total))
    else $error("read access length wrong");
  a_write_cycle_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (hold_end && wr_q && !ext_used_q) |-> (acc_cnt_q + 8'(1) == eff_total))
    else $error("write access length wrong");
  a_strobe_low_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($rose(o_output_enable_n) && !ext_used_q) |-> (low_cnt_q == eff_strobe))
    else $error("read strobe width wrong");
  a_wait_chunk_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($changed(ewc_q) && ewc_q != '0) |-> $past(in_extend, 16))
    else $error("wait chunk not sixteen cycles");
  a_read_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (in_extend && !i_wait_input && !wr_q) |-> ##4 $rose(o_output_enable_n))
    else $error("read strobe not released four cycles after wait");
  a_write_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (in_extend && !i_wait_input && wr_q) |-> !o_write_strobe_n[*4] ##1 o_write_strobe_n)
    else $error("write strobe not released four cycles after wait");
  a_wait_timeout: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (in_extend && i_wait_input && wait_limit) |=> in_hold ##[1:8] (o_rsp_valid && o_rsp_timeout))
    else $error("wait limit did not time out");
  a_select_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ss_q && !o_req_ready) |-> ((o_chip_select_n != 4'hF) == (!o_output_enable_n || !o_write_strobe_n)))
    else $error("chip select not following strobe");
  a_cs_one_hot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $onehot0(~o_chip_select_n) && (!o_req_ready || o_chip_select_n == 4'hF))
    else $error("chip select not one hot");
  a_addr_stable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!o_req_ready && !$past(o_req_ready)) |-> ($stable(o_ext_addr) && $stable(o_bank_addr)))
    else $error("address moved during access");
  a_write_data_span: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!o_write_strobe_n || $rose(o_write_strobe_n)) |-> (o_ext_data_oe && $past(o_ext_data_oe)))
    else $error("write data not driven across strobe");
  a_read_released: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!o_req_ready && !wr_q) |-> !o_ext_data_oe)
    else $error("data bus driven during read");

endmodule // async_memory_strobe_sequencer

`default_nettype wire

// ==== bench/memory_partner.sv ====
// sixteen word memory model with a programmable wait
// assumes pins change just after rising edges of i_clk
`timescale 1ns/10ps
`default_nettype none
module memory_partner (
  // clock
  input wire logic i_clk,
  // memory pins
  input wire logic [3:0] i_chip_select_n,
  input wire logic i_output_enable_n,
  input wire logic i_write_strobe_n,
  input wire logic [20:0] i_ext_addr,
  input wire logic [15:0] i_ext_data_out,
  input wire logic i_ext_data_oe,
  output logic [15:0] o_ext_data_in,
  output logic o_wait_input,
  // wait length in strobe cycles
  input wire logic [8:0] i_wait_len
);
  logic [15:0] mem_q [16];
  logic [15:0] last_q = 16'h0000;
  logic [8:0] cnt_q = 9'h000;
  wire logic sel = (i_chip_select_n != 4'hF);
  wire logic rd = sel && !i_output_enable_n;
  wire logic stb = sel && !(i_output_enable_n && i_write_strobe_n);
  initial o_wait_input = 1'b0;
  initial for (int i = 0; i < 16; i++) mem_q[i] = 16'h0000;
  // released bus shows a changing pattern
  assign o_ext_data_in = rd ? mem_q[i_ext_addr[3:0]] : ~last_q;
  always @(posedge i_clk) begin
    last_q <= o_ext_data_in;
    if (sel && !i_write_strobe_n && i_ext_data_oe) mem_q[i_ext_addr[3:0]] <= i_ext_data_out;
    cnt_q <= stb ? cnt_q + 9'h001 : 9'h000;
    // wait from strobe start, high for i_wait_len strobe cycles
    o_wait_input <= stb && (cnt_q < i_wait_len);
  end
endmodule // memory_partner
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench of the asynchronous memory strobe sequencer
// assumes memory_partner beside it and a 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_req_valid = 1'b0, i_req_write = 1'b0, i_extended_wait_enable = 1'b0, i_select_strobe_mode = 1'b0;
  logic [1:0] i_req_space = 2'h0, i_req_bank = 2'h0, i_bus_turnaround_cycles = 2'h0;
  logic [20:0] i_req_addr = 21'h000000;
  logic [15:0] i_req_wdata = 16'h0000, i_ext_data_in, o_rsp_rdata, o_ext_data_out;
  logic [3:0] i_read_setup_cycles = 4'h1, i_write_setup_cycles = 4'h1, o_chip_select_n;
  logic [5:0] i_read_strobe_cycles = 6'h01, i_write_strobe_cycles = 6'h01;
  logic [2:0] i_read_hold_cycles = 3'h1, i_write_hold_cycles = 3'h1;
  logic [7:0] i_wait_timeout_limit = 8'h01, o_external_wait_count;
  logic [8:0] i_wait_len = 9'h000;
  logic o_req_ready, o_rsp_valid, o_rsp_timeout, o_busy, o_output_enable_n, o_write_strobe_n;
  logic o_ext_data_oe, i_wait_input;
  logic [1:0] o_bank_addr;
  logic [20:0] o_ext_addr;
  logic [15:0] shadow [16];
  int fails = 0;
  int samples_checked = 0;
  always #2 i_clk = ~i_clk;
  async_memory_strobe_sequencer u_async_memory_strobe_sequencer (.i_clk, .i_sys_rst, .i_req_valid,
    .o_req_ready, .i_req_write, .i_req_space, .i_req_bank, .i_req_addr, .i_req_wdata, .o_rsp_valid,
    .o_rsp_rdata, .o_rsp_timeout, .i_read_setup_cycles, .i_read_strobe_cycles, .i_read_hold_cycles,
    .i_write_setup_cycles, .i_write_strobe_cycles, .i_write_hold_cycles, .i_bus_turnaround_cycles,
    .i_extended_wait_enable, .i_select_strobe_mode, .i_wait_timeout_limit, .o_busy,
    .o_external_wait_count, .o_chip_select_n, .o_output_enable_n, .o_write_strobe_n, .o_bank_addr,
    .o_ext_addr, .o_ext_data_out, .o_ext_data_oe, .i_ext_data_in, .i_wait_input);
  memory_partner u_memory_partner (.i_clk, .i_chip_select_n(o_chip_select_n),
    .i_output_enable_n(o_output_enable_n), .i_write_strobe_n(o_write_strobe_n), .i_ext_addr(o_ext_addr),
    .i_ext_data_out(o_ext_data_out), .i_ext_data_oe(o_ext_data_oe), .o_ext_data_in(i_ext_data_in),
    .o_wait_input(i_wait_input), .i_wait_len);
  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  function automatic int eff(input int v);
    return (v == 0) ? 1 : v;
  endfunction
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // one access with its expectations
  // ****************************************
  task automatic access(input bit wr, input int sp, s, t, h, ta, input bit ss, ew, input int wl, lim);
    int n, str, csl, pre, doe, wl4, k, mode;
    bit seen_w;
    n = 0; str = 0; csl = 0; pre = 0; doe = 0; wl4 = 0; k = 0; seen_w = 0;
    mode = !ew ? 0 : (wl >= 200) ? 2 : 1;
    i_req_write = wr; i_req_space = sp[1:0];
    i_req_bank = 2'($urandom); i_req_addr = 21'($urandom); i_req_wdata = 16'($urandom);
    i_read_setup_cycles = wr ? 4'hF : s[3:0]; i_write_setup_cycles = wr ? s[3:0] : 4'hF;
    i_read_strobe_cycles = wr ? 6'h3F : t[5:0]; i_write_strobe_cycles = wr ? t[5:0] : 6'h3F;
    i_read_hold_cycles = wr ? 3'h7 : h[2:0]; i_write_hold_cycles = wr ? h[2:0] : 3'h7;
    i_bus_turnaround_cycles = ta[1:0]; i_select_strobe_mode = ss; i_extended_wait_enable = ew;
    i_wait_len = wl[8:0]; i_wait_timeout_limit = lim[7:0];
    i_req_valid = 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    i_req_valid = 1'b0;
    chk(o_busy, 1);
    while (o_rsp_valid !== 1'b1 && n < 2000) begin
      n++;
      if (i_wait_input === 1'b1) seen_w = 1;
      if (o_chip_select_n !== 4'hF) begin
        csl++;
        chk(o_chip_select_n, 4'(~(4'h1 << sp)));
        chk({o_bank_addr, o_ext_addr}, {i_req_bank, i_req_addr});
        if (o_output_enable_n && o_write_strobe_n && str == 0) pre++;
      end
      if (!(o_output_enable_n && o_write_strobe_n)) begin
        str++;
        chk(wr ? o_output_enable_n : o_write_strobe_n, 1);
        if (seen_w && i_wait_input === 1'b0) wl4++;
      end
      if (o_ext_data_oe === 1'b1) begin
        doe++;
        chk(o_ext_data_out, i_req_wdata);
      end
      @(negedge i_clk);
    end
    if (n >= 2000) begin
      fails++;
      summarize();
    end
    chk(n, eff(s) + str + eff(h));
    if (mode == 0) chk(str, eff(t));
    if (mode == 1) chk(wl4, 4);
    if (mode == 2) chk(str, eff(t) + 16 * lim);
    if (mode == 2) chk(o_external_wait_count, lim);
    chk(o_rsp_timeout, mode == 2);
    chk(pre, ss ? 0 : eff(s));
    chk(csl - pre - str, ss ? 0 : eff(h));
    chk(doe, wr ? n : 0);
    if (wr) shadow[i_req_addr[3:0]] = i_req_wdata;
    else chk(o_rsp_rdata, shadow[i_req_addr[3:0]]);
    while (o_req_ready !== 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    chk(k, ta);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < 16; i++) shadow[i] = 16'h0000;
    void'($urandom(5725));
    repeat (8) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    chk({o_chip_select_n, o_output_enable_n, o_write_strobe_n, o_ext_data_oe, o_req_ready}, 8'hFD);
    access(1, 0, 0, 0, 0, 0, 0, 0, 0, 1);
    access(0, 3, 15, 63, 7, 3, 1, 0, 0, 1);
    access(1, 2, 15, 63, 7, 3, 0, 0, 0, 1);
    $display("corner accesses done");
    for (int i = 0; i < 30; i++) begin
      access($urandom % 2, $urandom % 4, $urandom % 16, $urandom % 12, $urandom % 8, $urandom % 4,
        $urandom % 2, 0, $urandom % 40, 1);
    end
    $display("random accesses done");
    for (int w = 0; w < 2; w++) begin
      access(w, 1, 2, 8, 2, 1, 0, 1, 28, 8);
      access(w, 2, 1, 6, 1, 0, 1, 1, 255, 2);
    end
    $display("wait accesses done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
